// [hdl/frio_pkg.sv]
// Contract
// [RULE1] remote bits are general I/O unless mapped
// [RULE2] each remote input maps to system input
// [RULE3] each remote output maps to indication
// [RULE4] mapped bit acts like connector signal
// [RULE5] command field carries 14-bit code
// [RULE6] data is signed, least byte first
// [RULE7] master scales user values by 1000; code sends data unscaled
// [RULE8] code 1142h writes start velocity
// [RULE9] master holds motor current bit on; code sends it as software writes it to CTRL
// [RULE10] act only when trigger goes high
// [RULE11] incremental move is five writes, then index
// [RULE12] capture on trigger rise; fields held stable
// [RULE13] ack set, command echoed, write returns zero
// [RULE14] error bit set on failed command
// [RULE15] byte1 bit5 turns motor current on
// [RULE16] command byte2, trigger byte3 bit6, data 4-7
// [RULE17] master drops trigger after each ack
package frio_pkg;
	// =====================================================
	// object layout
	localparam int FRIO_OBJ_BYTES    = 8;
	localparam int FRIO_CMD_W        = 14;
	localparam int FRIO_CMD_LSB      = 16;
	localparam int FRIO_COMMAND_TRIGGER_BIT     = 30;
	localparam int FRIO_STATUS_BIT   = 31;
	localparam int FRIO_CURRENT_BIT  = 13;
	localparam int FRIO_DATA_LSB     = 32;
	localparam int FRIO_RIN_N        = 8;
	localparam int FRIO_ROUT_N       = 6;
	// =====================================================
	// command codes
	localparam logic [13:0] FRIO_CMD_WR_VS  = 14'h1142;
	localparam logic [13:0] FRIO_CMD_RD_VS  = 14'h0142;
	localparam logic [13:0] FRIO_CMD_WR_VR  = 14'h1143;
	localparam logic [13:0] FRIO_CMD_RD_VR  = 14'h0143;
	localparam logic [13:0] FRIO_CMD_WR_TA  = 14'h1144;
	localparam logic [13:0] FRIO_CMD_WR_TD  = 14'h1145;
	localparam logic [13:0] FRIO_CMD_WR_DIS = 14'h1146;
	localparam logic [13:0] FRIO_CMD_MI     = 14'h1147;
	localparam logic [13:0] FRIO_CMD_MAP_IN = 14'h1180;
	localparam logic [13:0] FRIO_CMD_MAP_OUT = 14'h1181;
	localparam logic [31:0] FRIO_VS_MAX     = 32'h000f4240;
	localparam int          FRIO_SCALE      = 1000;
	// =====================================================
	// remote input functions (0 = general I/O)
	typedef enum logic [3:0] {
		FRIO_IN_GENERAL, FRIO_IN_FAULT_CLEAR, FRIO_IN_CONTINUE_MOTION, FRIO_IN_HOME_SENSOR,
		FRIO_IN_LIMIT_POSITIVE, FRIO_IN_LIMIT_NEGATIVE, FRIO_IN_MOTOR_HALT,
		FRIO_IN_SEEK_ORIGIN_POSITIVE, FRIO_IN_PAUSE, FRIO_IN_PAUSE_RELEASE,
		FRIO_IN_POSITION_ERROR_RESET, FRIO_IN_EMERGENCY_HALT, FRIO_IN_SENSOR,
		FRIO_IN_TORQUE_LIMIT_RELEASE
	} frio_in_fn_type;
	typedef enum logic [2:0] {
		FRIO_OUT_GENERAL, FRIO_OUT_POSITION_DATA_READY, FRIO_OUT_BRAKE_RELEASE,
		FRIO_OUT_PAUSED_FLAG, FRIO_OUT_SEQ_RUNNING
	} frio_out_fn_type;
	// =====================================================
	// software port of the master end
	localparam logic [3:0] FRIO_REG_CTRL    = 4'h0;
	localparam logic [3:0] FRIO_REG_CMD     = 4'h1;
	localparam logic [3:0] FRIO_REG_DATA    = 4'h2;
	localparam logic [3:0] FRIO_REG_RESULT  = 4'h3;
	localparam logic [3:0] FRIO_REG_RDATA   = 4'h4;
	localparam logic [3:0] FRIO_REG_IRQ_ST  = 4'h5;
	localparam logic [3:0] FRIO_REG_IRQ_MSK = 4'h6;
	localparam int FRIO_IRQ_DONE = 0;
	localparam int FRIO_IRQ_ERR  = 1;
endpackage

// [hdl/frio_link_if.sv]
`timescale 1ns/1ps
// receive object from master, transmit object back to it
interface frio_link_if;
	logic [63:0] rx_obj;
	logic [63:0] tx_obj;
	modport master (output rx_obj, input tx_obj);
	modport device (input rx_obj, output tx_obj);
endinterface

// [hdl/frio_device.sv]
`timescale 1ns/1ps
// device end: decodes the receive object and builds the transmit object
module frio_device
	import frio_pkg::*;
(
	// clock and reset
	input  wire logic                    clk_sys_i,
	input  wire logic                    rst_i,
	// link
	frio_link_if.device                  link,
	// connector-equivalent inputs and outputs
	input  wire logic                    position_data_ready_i,
	input  wire logic                    brake_release_i,
	input  wire logic                    paused_flag_i,
	input  wire logic                    seq_running_i,
	input  wire logic [7:0]              status_byte1_i,
	input  wire logic [1:0]              alarm_warn_i,
	output logic      [FRIO_RIN_N-1:0]   remote_in_bits_o,
	output logic      [13:0]             sys_in_fn_o,
	output logic                         motor_current_on_o,
	output logic      [7:0]              control_byte1_o,
	output logic      [31:0]             start_velocity_o,
	output logic      [31:0]             run_velocity_o,
	output logic      [31:0]             accel_time_o,
	output logic      [31:0]             decel_time_o,
	output logic      [31:0]             move_distance_o,
	output logic                         move_index_o
);
	// =====================================================
	// field extraction
	wire logic [FRIO_CMD_W-1:0] cmd_w  = link.rx_obj[FRIO_CMD_LSB +: FRIO_CMD_W]; // [RULE16]
	wire logic                  command_trigger_w = link.rx_obj[FRIO_COMMAND_TRIGGER_BIT];
	wire logic [31:0]           data_w = link.rx_obj[FRIO_DATA_LSB +: 32]; // [RULE6]
	wire logic [7:0]            rin_w  = link.rx_obj[7:0];
	logic       command_trigger_q;
	logic       ack_q, err_q;
	logic [13:0] echo_q;
	logic [31:0] rdata_q;
	logic [3:0]  in_map_q [FRIO_RIN_N];
	logic [2:0]  out_map_q [FRIO_ROUT_N];
	logic [FRIO_ROUT_N-1:0] rout_q;
	wire logic  rise_w = command_trigger_w & ~command_trigger_q; // [RULE12]
	wire logic  map_ok_w = (data_w[15:8] < 8'(FRIO_RIN_N)) && (data_w[7:0] < 8'd14);
	wire logic  omap_ok_w = (data_w[15:8] < 8'(FRIO_ROUT_N)) && (data_w[7:0] < 8'd5);
	// start velocity must be non-negative and within the limit
	wire logic  vs_ok_w = ~data_w[31] && (data_w <= FRIO_VS_MAX);
	wire logic  cur_on_w = link.rx_obj[FRIO_CURRENT_BIT]; // [RULE15]
	// connector-side indications gathered for the output selector
	wire logic [3:0] ind_w = {seq_running_i, paused_flag_i, brake_release_i, position_data_ready_i};
	// =====================================================
	// helpers
	// functions keep the decode lines short and alike
	// one code compare, shared by every decode line below
	function automatic logic frio_is_code(
		input logic [FRIO_CMD_W-1:0] seen,
		input logic [FRIO_CMD_W-1:0] code
	);
		return seen == code;
	endfunction
	// index field of a mapping command, the same for both directions
	function automatic logic [2:0] frio_map_index(input logic [31:0] word);
		return word[10:8];
	endfunction
	// indication that a remote output shows; general outputs idle low
	function automatic logic frio_pick_ind(
		input logic [2:0] fn,
		input logic [3:0] ind
	);
		logic pick;
		case (fn)
			3'h1: pick = ind[0]; // position data ready
			3'h2: pick = ind[1]; // brake released
			3'h3: pick = ind[2]; // paused
			3'h4: pick = ind[3]; // sequence running
			default: pick = 1'b0;
		endcase
		return pick;
	endfunction
	// =====================================================
	// command decode; a hit counts only on the trigger rise, so idle
	// field contents never reach a register
	// reads and writes of one parameter use different codes
	wire logic hit_wr_vs_w   = rise_w && frio_is_code(cmd_w, FRIO_CMD_WR_VS); // [RULE8]
	wire logic hit_rd_vs_w   = rise_w && frio_is_code(cmd_w, FRIO_CMD_RD_VS); // [RULE5]
	wire logic hit_wr_vr_w   = rise_w && frio_is_code(cmd_w, FRIO_CMD_WR_VR);
	wire logic hit_rd_vr_w   = rise_w && frio_is_code(cmd_w, FRIO_CMD_RD_VR);
	wire logic hit_wr_ta_w   = rise_w && frio_is_code(cmd_w, FRIO_CMD_WR_TA);
	wire logic hit_wr_td_w   = rise_w && frio_is_code(cmd_w, FRIO_CMD_WR_TD);
	wire logic hit_wr_dis_w  = rise_w && frio_is_code(cmd_w, FRIO_CMD_WR_DIS);
	wire logic hit_mi_w      = rise_w && frio_is_code(cmd_w, FRIO_CMD_MI);
	wire logic hit_map_in_w  = rise_w && frio_is_code(cmd_w, FRIO_CMD_MAP_IN); // [RULE2]
	wire logic hit_map_out_w = rise_w && frio_is_code(cmd_w, FRIO_CMD_MAP_OUT); // [RULE3]
	// the code list is fixed; any other code fails
	wire logic hit_any_w     = hit_wr_vs_w | hit_rd_vs_w | hit_wr_vr_w | hit_rd_vr_w | hit_wr_ta_w
		| hit_wr_td_w | hit_wr_dis_w | hit_mi_w | hit_map_in_w | hit_map_out_w;
	// accepted actions
	wire logic set_vs_w      = hit_wr_vs_w && vs_ok_w;
	wire logic start_w       = hit_mi_w && cur_on_w; // no move while current is off
	wire logic set_imap_w    = hit_map_in_w && map_ok_w;
	wire logic set_omap_w    = hit_map_out_w && omap_ok_w;
	// failure causes: out of range, not allowed now, or an unknown code;
	// a failed command still echoes its code and raises the ack
	wire logic fail_w = (hit_wr_vs_w && !vs_ok_w) || (hit_mi_w && !cur_on_w)
		|| (hit_map_in_w && !map_ok_w) || (hit_map_out_w && !omap_ok_w)
		|| (rise_w && !hit_any_w); // [RULE14]
	// reads answer a stored value; writes and failures answer zero
	wire logic [31:0] ret_w =
		hit_rd_vs_w ? start_velocity_o :
		hit_rd_vr_w ? run_velocity_o : 32'h00000000; // [RULE13]
	wire logic [2:0]  map_idx_w = frio_map_index(data_w);
	// =====================================================
	// handshake: ack rises with the command and falls with the trigger
	// ack is cleared only by the trigger, never by a timeout, so the
	// master must drop the trigger for a cycle before the next command
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			command_trigger_q <= 1'b0;
			ack_q  <= 1'b0;
		end else begin
			command_trigger_q <= command_trigger_w;
			if (rise_w) ack_q <= 1'b1; // [RULE13]
			else if (!command_trigger_w) ack_q <= 1'b0;
		end
	end
	// result fields stand until the next command, so a slow master
	// still reads them after it has seen the ack
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			err_q   <= 1'b0;
			echo_q  <= 14'h0000;
			rdata_q <= 32'h00000000;
		end else if (rise_w) begin // [RULE10] [RULE12]
			err_q   <= fail_w; // [RULE14]
			echo_q  <= cmd_w; // [RULE13]
			rdata_q <= ret_w; // [RULE13]
		end
	end
	// =====================================================
	// motion parameters; a refused value leaves the old one standing
	// values are stored as sent; only the start velocity has a limit
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			start_velocity_o <= 32'h00000000;
			run_velocity_o   <= 32'h00000000;
			accel_time_o     <= 32'h00000000;
			decel_time_o     <= 32'h00000000;
			move_distance_o  <= 32'h00000000;
		end else begin
			if (set_vs_w) start_velocity_o <= data_w; // [RULE8]
			if (hit_wr_vr_w) run_velocity_o <= data_w;
			if (hit_wr_ta_w) accel_time_o <= data_w;
			if (hit_wr_td_w) decel_time_o <= data_w;
			if (hit_wr_dis_w) move_distance_o <= data_w;
		end
	end
	// move start is a one-cycle pulse, refused while current is off
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) move_index_o <= 1'b0;
		else move_index_o <= start_w;
	end
	// =====================================================
	// mapping tables; zero means general I/O
	// two bits may share one function: their inputs are ORed together
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			for (int i = 0; i < FRIO_RIN_N; i++) in_map_q[i] <= 4'h0; // [RULE1]
			for (int i = 0; i < FRIO_ROUT_N; i++) out_map_q[i] <= 3'h0;
		end else begin
			if (set_imap_w) in_map_q[map_idx_w] <= data_w[3:0]; // [RULE2]
			if (set_omap_w) out_map_q[map_idx_w] <= data_w[2:0]; // [RULE3]
		end
	end
	// =====================================================
	// remote bit routing; a mapped bit leaves general use
	always_comb begin
		logic [13:0] fn;
		logic [FRIO_RIN_N-1:0] gen;
		fn = 14'h0000;
		gen = '0;
		for (int i = 0; i < FRIO_RIN_N; i++) begin
			if (in_map_q[i] == 4'h0) gen[i] = rin_w[i]; // [RULE1]
			else fn[in_map_q[i]] = fn[in_map_q[i]] | rin_w[i]; // [RULE4]
		end
		remote_in_bits_o = gen;
		sys_in_fn_o = fn;
	end
	assign motor_current_on_o = link.rx_obj[FRIO_CURRENT_BIT]; // [RULE15]
	assign control_byte1_o = link.rx_obj[15:8];
	// =====================================================
	// remote outputs take the mapped indication one cycle late,
	// like a connector output sampled on the same clock
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rout_q <= '0;
		end else begin
			for (int i = 0; i < FRIO_ROUT_N; i++) begin
				rout_q[i] <= frio_pick_ind(out_map_q[i], ind_w); // [RULE3] [RULE4]
			end
		end
	end
	// =====================================================
	// transmit object: data, error, ack, echo, status byte, alarm
	// and warning, remote outputs; nothing here waits on the master
	assign link.tx_obj = {rdata_q, err_q, ack_q, echo_q,
		status_byte1_i, alarm_warn_i, rout_q};
endmodule

// [hdl/frio_master.sv]
`timescale 1ns/1ps
// master end: software queues one command, this end raises the trigger
module frio_master
	import frio_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// software port
	input  wire logic [3:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	output logic             irq_o,
	// link
	frio_link_if.master      link
);
	typedef enum logic [1:0] {FRIO_M_IDLE, FRIO_M_WAIT, FRIO_M_DROP} frio_mst_type;
	frio_mst_type st_q;
	logic [7:0]  ctrl_q;
	logic [7:0]  rin_q;
	logic [13:0] cmd_q;
	logic [31:0] data_q, res_data_q;
	logic        command_trigger_q, res_err_q;
	logic [1:0]  irq_st_q, irq_msk_q;
	wire logic ack_w = link.tx_obj[FRIO_COMMAND_TRIGGER_BIT];
	wire logic go_w  = wr_i && addr_i == FRIO_REG_CMD && st_q == FRIO_M_IDLE;
	wire logic done_w = st_q == FRIO_M_WAIT && ack_w;
	// =====================================================
	// byte 0 remote inputs, byte 1 control (current bit 5)
	assign link.rx_obj = {data_q, 1'b0, command_trigger_q, cmd_q, ctrl_q, rin_q}; // [RULE16] [RULE6]
	// =====================================================
	// command sequencer
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			st_q <= FRIO_M_IDLE;
			command_trigger_q <= 1'b0;
			cmd_q <= 14'h0000;
			data_q <= 32'h00000000;
			ctrl_q <= 8'h00;
			rin_q <= 8'h00;
			res_err_q <= 1'b0;
			res_data_q <= 32'h00000000;
		end else begin
			if (wr_i && addr_i == FRIO_REG_CTRL) {rin_q, ctrl_q} <= wdata_i[15:0]; // [RULE9]
			if (wr_i && addr_i == FRIO_REG_DATA && st_q == FRIO_M_IDLE) data_q <= wdata_i; // [RULE7]
			case (st_q)
				FRIO_M_IDLE: if (go_w) begin
					cmd_q <= wdata_i[13:0]; // [RULE5]
					command_trigger_q <= 1'b1; // command field is set on the same edge as the trigger [RULE12]
					st_q <= FRIO_M_WAIT;
				end
				FRIO_M_WAIT: if (ack_w) begin
					res_err_q <= link.tx_obj[FRIO_STATUS_BIT];
					res_data_q <= link.tx_obj[FRIO_DATA_LSB +: 32];
					command_trigger_q <= 1'b0; // [RULE17]
					st_q <= FRIO_M_DROP;
				end
				FRIO_M_DROP: if (!ack_w) st_q <= FRIO_M_IDLE; // one command per trigger [RULE11]
				default: st_q <= FRIO_M_IDLE;
			endcase
		end
	end
	// =====================================================
	// interrupt status, set wins over clear
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			irq_st_q <= 2'b00;
			irq_msk_q <= 2'b00;
		end else begin
			if (wr_i && addr_i == FRIO_REG_IRQ_MSK) irq_msk_q <= wdata_i[1:0];
			irq_st_q <= (irq_st_q & ~((wr_i && addr_i == FRIO_REG_IRQ_ST) ? wdata_i[1:0] : 2'b00))
				| {done_w & link.tx_obj[FRIO_STATUS_BIT], done_w};
		end
	end
	assign irq_o = |(irq_st_q & irq_msk_q);
	// read mux, data one cycle after the strobe
	wire logic [31:0] rmux_w =
		(addr_i == FRIO_REG_CTRL)    ? {16'h0000, rin_q, ctrl_q} :
		(addr_i == FRIO_REG_CMD)     ? {18'h0, cmd_q} :
		(addr_i == FRIO_REG_DATA)    ? data_q :
		(addr_i == FRIO_REG_RESULT)  ? {29'h0, st_q != FRIO_M_IDLE, res_err_q, link.tx_obj[FRIO_COMMAND_TRIGGER_BIT]} :
		(addr_i == FRIO_REG_RDATA)   ? res_data_q :
		(addr_i == FRIO_REG_IRQ_ST)  ? {30'h0, irq_st_q} :
		(addr_i == FRIO_REG_IRQ_MSK) ? {30'h0, irq_msk_q} : 32'h00000000;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) rdata_o <= 32'h00000000;
		else if (rd_i) rdata_o <= rmux_w;
		else rdata_o <= 32'h00000000;
	end
endmodule

// [verification/frio_asserts.sv]
`timescale 1ns/1ps
// link checker: sits beside the interface, watches both objects
module frio_asserts
	import frio_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// link objects
	input  wire logic [63:0] rx_obj,
	input  wire logic [63:0] tx_obj
);
	// ==========================================
	// field decode, trigger edge helper
	wire logic [13:0] cmd_w  = rx_obj[29:16];
	wire logic        trg_w  = rx_obj[30];
	wire logic        ack_w  = tx_obj[30];
	logic             trg_q;
	logic             rise_q;
	wire logic        rise_w = trg_w & ~trg_q;
	// registered so the edge is not confused with the level
	always_ff @(posedge clk_sys_i) begin
		trg_q  <= rst_i ? 1'b0 : trg_w;
		rise_q <= rst_i ? 1'b0 : rise_w;
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// ==========================================
	// handshake and result checks
	chk_ack_bound: assert property (rise_w |-> ##[1:2] ack_w)
		else $error("no ack after trigger rise");
	chk_ack_cause: assert property ($rose(ack_w) |-> trg_w && ($past(rise_w) || $past(rise_w, 2)))
		else $error("ack without trigger rise");
	chk_ack_drop: assert property (!trg_w |-> ##[1:2] !ack_w)
		else $error("ack held after trigger low");
	chk_echo_cmd: assert property ($rose(ack_w) |-> tx_obj[29:16] == cmd_w)
		else $error("echoed command differs");
	chk_write_zero: assert property ($rose(ack_w) && cmd_w == FRIO_CMD_WR_VS |-> tx_obj[63:32] == 32'h0)
		else $error("write returned nonzero data");
	chk_vs_range: assert property ($rose(ack_w) && cmd_w == FRIO_CMD_WR_VS
		|-> tx_obj[31] == (rx_obj[63] || rx_obj[63:32] > FRIO_VS_MAX))
		else $error("start velocity range error wrong");
	chk_unknown_err: assert property ($rose(ack_w) && cmd_w[13:12] >= 2'h2 |-> tx_obj[31])
		else $error("unknown command without error");
	chk_mi_current: assert property ($rose(ack_w) && cmd_w == FRIO_CMD_MI && !rx_obj[13] |-> tx_obj[31])
		else $error("move accepted with current off");
	chk_hold_result: assert property (!rise_w && !rise_q |=> $stable({tx_obj[63:31], tx_obj[29:16]}))
		else $error("result changed without command");
	// main scenarios reached
	cov_error: cover property (rise_w ##[1:2] tx_obj[31]);
	cov_move: cover property ($rose(ack_w) && cmd_w == FRIO_CMD_MI);
	cov_map: cover property (rise_w && cmd_w == FRIO_CMD_MAP_IN);
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps
// both ends joined on one link, software port driven by tasks
module testbench;
	import frio_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic [3:0]  addr_i    = 4'h0;
	logic [31:0] wdata_i   = 32'h0;
	logic        wr_i      = 1'b0;
	logic        rd_i      = 1'b0;
	logic [3:0]  ind       = 4'h0;
	logic [7:0]  sts       = 8'h5a;
	logic [1:0]  alw       = 2'h2;
	int          mi_cnt    = 0;
	logic        motor_current_on       = 1'b1;
	logic [31:0] rdata_o, v, d, vs, vr, seed;
	logic [31:0] par [5];
	logic [7:0]  rin, rin_o, cb1;
	logic [13:0] sys_fn;
	logic        irq_o, cur_o, mi_o;
	int          n_mismatch, check_count;
	frio_link_if link ();
	frio_master frio_master_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .link(link.master));
	frio_device frio_device_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link.device),
		.position_data_ready_i(ind[0]), .brake_release_i(ind[1]), .paused_flag_i(ind[2]),
		.seq_running_i(ind[3]), .status_byte1_i(sts), .alarm_warn_i(alw), .remote_in_bits_o(rin_o),
		.sys_in_fn_o(sys_fn), .motor_current_on_o(cur_o), .control_byte1_o(cb1),
		.start_velocity_o(par[0]), .run_velocity_o(par[1]), .accel_time_o(par[2]),
		.decel_time_o(par[3]), .move_distance_o(par[4]), .move_index_o(mi_o));
	frio_asserts frio_asserts_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .rx_obj(link.rx_obj),
		.tx_obj(link.tx_obj));
	// ================================================
	// clock, pulse catcher
	always #4 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (mi_o) mi_cnt <= mi_cnt + 1;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// ================================================
	// software port cycles; strobe drops one cycle so no same-step reassign
	task wr(input logic [3:0] a, input logic [31:0] dw);
		addr_i  <= a;
		wdata_i <= dw;
		wr_i    <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task rd(input logic [3:0] a, output logic [31:0] r);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 r = rdata_o;
		@(posedge clk_sys_i);
	endtask
	// expected error flag from the command rules
	function automatic logic exp_err(logic [13:0] c, logic [31:0] x);
		case (c)
			FRIO_CMD_WR_VS:   return x[31] || x > FRIO_VS_MAX;
			FRIO_CMD_MI:      return !motor_current_on;
			FRIO_CMD_MAP_IN:  return x[15:8] >= 8'(FRIO_RIN_N) || x[7:0] >= 8'h0e;
			FRIO_CMD_MAP_OUT: return x[15:8] >= 8'(FRIO_ROUT_N) || x[7:0] >= 8'h05;
			FRIO_CMD_RD_VS, FRIO_CMD_RD_VR: return 1'b0;
			FRIO_CMD_WR_VR, FRIO_CMD_WR_TA, FRIO_CMD_WR_TD, FRIO_CMD_WR_DIS: return 1'b0;
			default:          return 1'b1;
		endcase
	endfunction
	// one command: queue, poll done, check result, clear interrupt
	task run(input logic [13:0] c, input logic [31:0] x, input logic [31:0] rexp);
		logic [31:0] r;
		r = 32'h0;
		wr(FRIO_REG_DATA, x);
		wr(FRIO_REG_CMD, {18'h0, c});
		for (int i = 0; i < 20 && !r[0]; i++) rd(FRIO_REG_IRQ_ST, r);
		chk(32'(r[1:0]), {30'h0, exp_err(c, x), 1'b1});
		chk(32'(irq_o), 32'h1);
		chk(32'(link.tx_obj[29:16]), 32'(c));
		rd(FRIO_REG_RDATA, r);
		chk(r, rexp);
		wr(FRIO_REG_IRQ_ST, 32'h3);
		chk(32'(irq_o), 32'h0);
	endtask
	task results;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// watchdog well beyond the expected run
	initial begin
		#200000;
		n_mismatch++;
		results();
	end
	// ================================================
	// main sequence
	initial begin
		seed = 32'hce59;
		repeat (20) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		rd(FRIO_REG_RESULT, v);
		chk(v, 32'h0);
		rd(4'hf, v);
		chk(v, 32'h0);
		chk({6'h0, link.tx_obj[31:6]}, {22'h0, sts, alw});
		rin = 8'($random(seed));
		wr(FRIO_REG_CTRL, {16'h0, rin, 8'h20});
		wr(FRIO_REG_IRQ_MSK, 32'h3);
		chk(32'(cur_o), 32'h1);
		chk(32'(cb1), 32'h20);
		chk(32'(link.rx_obj[15:0]), {16'h0, 8'h20, rin});
		chk(32'(rin_o), 32'(rin));
		// five parameter writes, then the move index
		for (int i = 0; i < 5; i++) begin
			d = $random(seed) & 32'h7ffff;
			if (i == 0) vs = d;
			if (i == 1) vr = d;
			run(FRIO_CMD_WR_VS + 14'(i), d, 32'h0);
			chk(par[i], d);
		end
		run(FRIO_CMD_RD_VS, 32'h0, vs);
		run(FRIO_CMD_RD_VR, 32'h0, vr);
		run(FRIO_CMD_WR_VS, 32'hffffff9c, 32'h0);
		run(FRIO_CMD_WR_VS, FRIO_VS_MAX + 32'h1, 32'h0);
		chk(par[0], vs);
		run(FRIO_CMD_WR_VS, FRIO_VS_MAX, 32'h0);
		chk(par[0], FRIO_VS_MAX);
		run(FRIO_CMD_WR_VS, 32'(FRIO_SCALE / 10), 32'h0);
		chk(par[0], 32'h64);
		run(FRIO_CMD_MI, 32'h0, 32'h0);
		chk(32'(mi_cnt), 32'h1);
		run(14'h2abc, 32'h0, 32'h0);
		for (int f = 1; f < 15; f++) begin
			run(FRIO_CMD_MAP_IN, 32'((f % 8) << 8 | f), 32'h0);
			if (f < 14) chk(32'(sys_fn[f]), 32'(rin[f % 8]));
			if (f < 14) chk(32'(rin_o[f % 8]), 32'h0);
		end
		wr(FRIO_REG_CTRL, {16'h0, ~rin, 8'h20});
		chk(32'(sys_fn[8]), {31'h0, ~rin[0]});
		ind <= 4'($random(seed));
		for (int f = 1; f < 5; f++) begin
			run(FRIO_CMD_MAP_OUT, 32'(f << 8 | f), 32'h0);
			chk(32'(link.tx_obj[f]), 32'(ind[f-1]));
		end
		chk(32'(link.tx_obj[5]), 32'h0);
		run(FRIO_CMD_MAP_OUT, 32'h0601, 32'h0);
		motor_current_on = 1'b0;
		wr(FRIO_REG_CTRL, {16'h0, rin, 8'h00});
		chk(32'(cur_o), 32'h0);
		chk(32'(cb1), 32'h0);
		run(FRIO_CMD_MI, 32'h0, 32'h0);
		chk(32'(mi_cnt), 32'h1);
		results();
	end
endmodule
